// ==== rtl/ashc_device.sv ====
// accessory switch device: i2c slave, registers, detection, path switch
// Function
// - reset loads defaults, opens all switch paths
// - after reset detection runs in standby
// - power-on reset from first battery rising edge
// - writing reset bit at 0x1b resets device
// - fast-mode slave works up to 400 khz
// - slave follows i2c specification revision 2.1
// - answers address 0100101, bit0 gives direction
// - master stops after first data byte: acknowledged on a write, not acknowledged (nack) on a read
// - all status and configuration via i2c registers
// - i2c and interrupt need battery and io supply
// - manual or automatic path switching selectable
// - factory cable routes to uart or usb path
// - interrupt low after id or attach change
// - interrupts off until mask bit cleared
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ashc_device
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   // supplies and sensing
   input  wire logic       i_bat_valid,
   input  wire logic       i_host_io_supply,
   input  wire logic       i_usb_bus_voltage_in,
   input  wire logic [4:0] i_connector_id_sense,
   // switch paths and factory signals
   output logic            o_path_host,
   output logic            o_path_host1,
   output logic            o_factory_boot,
   output logic            o_factory_mode,
   // processor link
   ashc_if.dev             bus
);
   typedef enum {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_RD, ST_MACK} ashc_dst_t;

   // ==========================================================
   // input synchronisers: {bat, io, vbus, id[4:0], scl, sda}
   logic [9:0] s1_ff;
   logic [9:0] s2_ff;
   logic [9:0] s3_ff;
   always_ff @(posedge i_clk)
   begin
      s1_ff <= {i_bat_valid, i_host_io_supply, i_usb_bus_voltage_in, i_connector_id_sense,
                bus.scl, bus.sda};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
   end

   logic       io_ok;
   logic       vbus;
   logic [4:0] id_code;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;
   assign io_ok     = s2_ff[9] & s2_ff[8];
   assign vbus      = s2_ff[7];
   assign id_code   = s2_ff[6:2];
   assign scl_rise  = s2_ff[1] & ~s3_ff[1];
   assign scl_fall  = ~s2_ff[1] & s3_ff[1];
   assign i2c_start = s2_ff[1] & s3_ff[1] & s3_ff[0] & ~s2_ff[0];
   assign i2c_stop  = s2_ff[1] & s3_ff[1] & ~s3_ff[0] & s2_ff[0];

   // ==========================================================
   // power-on and software reset
   logic bat_seen_ff;
   logic por_ff;
   logic swrst_ff;
   logic rst_all;
   logic wr_stb_ff;
   logic [7:0] wr_addr_ff;
   logic [7:0] wr_data_ff;
   // only the first battery rise counts; later dips are not a reset
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         bat_seen_ff <= 1'b0;
         por_ff      <= 1'b0;
      end
      else
      begin
         bat_seen_ff <= bat_seen_ff | s2_ff[9];
         por_ff      <= s2_ff[9] & ~s3_ff[9] & ~bat_seen_ff;
      end
   end

   // one-cycle pulse, so the reset releases by itself
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         swrst_ff <= 1'b0;
      else
         swrst_ff <= wr_stb_ff & (wr_addr_ff == ashc_pkg::REG_SW_RESET)
                     & wr_data_ff[ashc_pkg::SW_RESET_BIT];
   end
   assign rst_all = i_srst | por_ff | swrst_ff;

   // ==========================================================
   // configuration and status registers
   logic [7:0] control_ff;
   logic [7:0] manual_ff;
   logic [1:0] int_ff;
   logic [1:0] dev_type;
   logic [1:0] attach_prev_ff;
   logic [4:0] id_prev_ff;
   logic [7:0] adc_ff;
   logic       int_clr_ff;
   logic       factory_usb;
   logic       factory_uart;
   logic [1:0] events;
   assign factory_usb  = (id_code == ashc_pkg::ID_USB_OFF) | (id_code == ashc_pkg::ID_USB_ON);
   assign factory_uart = (id_code == ashc_pkg::ID_UART_OFF) | (id_code == ashc_pkg::ID_UART_ON);
   assign dev_type     = {factory_usb | factory_uart, vbus};
   assign events[ashc_pkg::INT_ATTACH] = dev_type != attach_prev_ff;
   assign events[ashc_pkg::INT_ID_CHG] = id_code != id_prev_ff;

   // register write port, driven by the slave
   always_ff @(posedge i_clk)
   begin
      if (rst_all)
      begin
         control_ff <= ashc_pkg::CONTROL_RST;
         manual_ff  <= ashc_pkg::MANUAL_RST;
      end
      else if (wr_stb_ff)
      begin
         if (wr_addr_ff == ashc_pkg::REG_CONTROL)
            control_ff <= wr_data_ff;
         if (wr_addr_ff == ashc_pkg::REG_MANUAL)
            manual_ff <= wr_data_ff;
      end
   end

   // detection runs from reset on; a new event beats a read clear
   always_ff @(posedge i_clk)
   begin
      if (rst_all)
      begin
         int_ff         <= 2'h0;
         attach_prev_ff <= 2'h0;
         id_prev_ff     <= ashc_pkg::ID_OPEN;
         adc_ff         <= {3'h0, ashc_pkg::ID_OPEN};
      end
      else
      begin
         attach_prev_ff <= dev_type;
         id_prev_ff     <= id_code;
         adc_ff         <= {3'h0, id_code};
         int_ff         <= (int_ff & {2{~int_clr_ff}}) | events;
      end
   end

   // ==========================================================
   // switch path control, open during any reset
   always_ff @(posedge i_clk)
   begin
      if (rst_all)
      begin
         o_path_host    <= 1'b0;
         o_path_host1   <= 1'b0;
         o_factory_boot <= 1'b0;
         o_factory_mode <= 1'b0;
      end
      else
      begin
         o_factory_mode <= factory_usb | factory_uart;
         o_factory_boot <= (id_code == ashc_pkg::ID_USB_ON) | (id_code == ashc_pkg::ID_UART_ON);
         if (control_ff[ashc_pkg::CTL_AUTO_SW])
         begin
            o_path_host  <= factory_usb | (vbus & (id_code == ashc_pkg::ID_OPEN));
            o_path_host1 <= factory_uart;
         end
         else
         begin
            o_path_host  <= manual_ff[ashc_pkg::MAN_HOST];
            o_path_host1 <= manual_ff[ashc_pkg::MAN_HOST1] & ~manual_ff[ashc_pkg::MAN_HOST];
         end
      end
   end

   // interrupt pin idles high and is silent without io supply
   always_ff @(posedge i_clk)
   begin
      if (rst_all)
         bus.attach_interrupt_n <= 1'b1;
      else
         bus.attach_interrupt_n <= ~(io_ok & ~control_ff[ashc_pkg::CTL_INT_MASK]
                                     & |int_ff);
   end

   // ==========================================================
   // read mux
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         ashc_pkg::REG_CONTROL:  reg_read = control_ff;
         ashc_pkg::REG_INT:      reg_read = {6'h00, int_ff};
         ashc_pkg::REG_ADC:      reg_read = adc_ff;
         ashc_pkg::REG_DEV_TYPE: reg_read = {6'h00, dev_type};
         ashc_pkg::REG_MANUAL:   reg_read = manual_ff;
         default:                reg_read = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // i2c slave; sda changes only after scl falls
   ashc_dst_t  st_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sr_ff;
   logic [7:0] ptr_ff;
   logic       rw_ff;
   logic       have_ptr_ff;
   logic       sda_low_ff;
   logic [7:0] rd_byte;
   assign rd_byte     = reg_read(ptr_ff);
   assign bus.d_sda_o    = 1'b0;
   assign bus.d_sda_oe_n = ~sda_low_ff;

   // software reset leaves the slave alone so the ack of that write completes
   always_ff @(posedge i_clk)
   begin
      wr_stb_ff  <= 1'b0;
      int_clr_ff <= 1'b0;
      if (i_srst || por_ff || !io_ok)
      begin
         st_ff       <= ST_IDLE;
         cnt_ff      <= 4'h0;
         sr_ff       <= 8'h00;
         ptr_ff      <= 8'h00;
         rw_ff       <= 1'b0;
         have_ptr_ff <= 1'b0;
         sda_low_ff  <= 1'b0;
         wr_addr_ff  <= 8'h00;
         wr_data_ff  <= 8'h00;
      end
      else if (i2c_start)
      begin
         st_ff      <= ST_ADDR;
         cnt_ff     <= 4'h0;
         sda_low_ff <= 1'b0;
      end
      else if (i2c_stop)
      begin
         st_ff      <= ST_IDLE;
         sda_low_ff <= 1'b0;
      end
      else
      begin
         case (st_ff)
            ST_ADDR, ST_RX:
               if (scl_rise)
               begin
                  sr_ff  <= {sr_ff[6:0], s2_ff[0]};
                  cnt_ff <= cnt_ff + 4'h1;
               end
               else if (scl_fall && cnt_ff == 4'h8)
               begin
                  cnt_ff <= 4'h0;
                  if (st_ff == ST_ADDR)
                  begin
                     if (sr_ff[7:1] == ashc_pkg::SLAVE_ADDR)
                     begin
                        sda_low_ff  <= 1'b1;
                        rw_ff       <= sr_ff[0];
                        have_ptr_ff <= 1'b0;
                        st_ff       <= ST_ACK;
                     end
                     else
                        st_ff <= ST_IDLE;
                  end
                  else
                  begin
                     sda_low_ff  <= 1'b1;
                     st_ff       <= ST_ACK;
                     have_ptr_ff <= 1'b1;
                     if (!have_ptr_ff)
                        ptr_ff <= sr_ff;
                     else
                     begin
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= sr_ff;
                        ptr_ff     <= ptr_ff + 8'h01;
                     end
                  end
               end
            ST_ACK:
               if (scl_fall)
               begin
                  cnt_ff <= 4'h0;
                  if (rw_ff)
                  begin
                     sr_ff      <= rd_byte;
                     sda_low_ff <= ~rd_byte[7];
                     int_clr_ff <= ptr_ff == ashc_pkg::REG_INT;
                     ptr_ff     <= ptr_ff + 8'h01;
                     st_ff      <= ST_RD;
                  end
                  else
                  begin
                     sda_low_ff <= 1'b0;
                     st_ff      <= ST_RX;
                  end
               end
            ST_RD:
               if (scl_rise)
                  cnt_ff <= cnt_ff + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt_ff == 4'h8)
                  begin
                     sda_low_ff <= 1'b0;
                     st_ff      <= ST_MACK;
                  end
                  else
                  begin
                     sr_ff      <= {sr_ff[6:0], 1'b0};
                     sda_low_ff <= ~sr_ff[6];
                  end
               end
            ST_MACK:
               if (scl_rise)
                  st_ff <= s2_ff[0] ? ST_IDLE : ST_ACK;
            default:
               st_ff <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== shared/ashc_pkg.sv ====
// shared constants for the accessory switch device and its i2c master
package ashc_pkg;
   // ==========================================================
   // i2c link
   localparam logic [6:0] SLAVE_ADDR   = 7'h25;
   localparam int         CLK_KHZ      = 50000;
   localparam int         SCL_MAX_KHZ  = 400;
   // quarter of the fastest scl period, rounded up so scl never beats 400 khz
   localparam int         I2C_QTR_CYC  = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
   // ==========================================================
   // device register map
   localparam logic [7:0] REG_CONTROL  = 8'h02;
   localparam logic [7:0] REG_INT      = 8'h03;
   localparam logic [7:0] REG_ADC      = 8'h07;
   localparam logic [7:0] REG_DEV_TYPE = 8'h0a;
   localparam logic [7:0] REG_MANUAL   = 8'h13;
   localparam logic [7:0] REG_SW_RESET = 8'h1b;
   localparam int         CTL_INT_MASK = 0;
   localparam int         CTL_AUTO_SW  = 2;
   localparam logic [7:0] CONTROL_RST  = 8'h05;
   localparam logic [7:0] MANUAL_RST   = 8'h00;
   localparam int         INT_ATTACH   = 0;
   localparam int         INT_ID_CHG   = 1;
   localparam int         SW_RESET_BIT = 0;
   localparam int         MAN_HOST     = 0;
   localparam int         MAN_HOST1    = 1;
   // ==========================================================
   // id sense codes
   localparam logic [4:0] ID_OPEN      = 5'h1f;
   localparam logic [4:0] ID_USB_OFF   = 5'h18;
   localparam logic [4:0] ID_USB_ON    = 5'h19;
   localparam logic [4:0] ID_UART_OFF  = 5'h1c;
   localparam logic [4:0] ID_UART_ON   = 5'h1d;
   // ==========================================================
   // controller registers on avalon (byte addresses)
   localparam logic [3:0] AV_CMD       = 4'h0;
   localparam logic [3:0] AV_STATUS    = 4'h4;
   localparam logic [3:0] AV_IRQ_STAT  = 4'h8;
   localparam logic [3:0] AV_IRQ_MASK  = 4'hc;
   localparam int         IRQ_DONE     = 0;
   localparam int         IRQ_ATTACH   = 1;
endpackage

// ==== shared/ashc_if.sv ====
// open-drain i2c wires and interrupt line between the two ends
`timescale 1ns/1ps
`default_nettype none
interface ashc_if;
   logic h_scl_o;
   logic h_scl_oe_n;
   logic h_sda_o;
   logic h_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic attach_interrupt_n;
   logic scl;
   logic sda;
   // pull-ups: a line is low only while some end enables a low drive
   assign scl = h_scl_oe_n | h_scl_o;
   assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
   modport dev  (input scl, sda, output d_sda_o, d_sda_oe_n, attach_interrupt_n);
   modport host (input scl, sda, attach_interrupt_n,
                 output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n);
endinterface
`default_nettype wire

// ==== rtl/ashc_host.sv ====
// i2c master controller for the accessory switch, driven over avalon-mm
`timescale 1ns/1ps
`default_nettype none
module ashc_host
#(
   parameter int QTR = ashc_pkg::I2C_QTR_CYC
)
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // avalon-mm slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // interrupt
   output logic             o_irq,
   // device link
   ashc_if.host             bus
);
   typedef enum {M_IDLE, M_START, M_BIT, M_STOP} ashc_mst_t;

   // ==========================================================
   if (QTR < 2 || QTR > 65535)
   begin : g_chk
      $error("QTR out of range");
   end

   // ==========================================================
   // pin synchronisers {sda, interrupt}
   logic [1:0] p1_ff;
   logic [1:0] p2_ff;
   always_ff @(posedge i_clk)
   begin
      p1_ff <= {bus.sda, bus.attach_interrupt_n};
      p2_ff <= p1_ff;
   end

   // ==========================================================
   // avalon slave: every access answers one cycle after it is seen
   logic        resp_ff;
   logic        wr_now;
   logic        go;
   logic        busy;
   logic        nack_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  cmd_reg_ff;
   logic [7:0]  cmd_data_ff;
   logic        cmd_rd_ff;
   logic [1:0]  irq_st_ff;
   logic [1:0]  irq_en_ff;
   logic        done_ff;
   ashc_mst_t   st_ff;
   assign busy              = st_ff != M_IDLE;
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~resp_ff;
   assign wr_now            = i_avs_write & resp_ff;
   assign go = wr_now & (i_avs_address == ashc_pkg::AV_CMD) & i_avs_writedata[0] & ~busy;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         resp_ff        <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         resp_ff <= (i_avs_read | i_avs_write) & ~resp_ff;
         if (i_avs_read && !resp_ff)
         begin
            case (i_avs_address)
               ashc_pkg::AV_CMD:      o_avs_readdata <= {8'h00, cmd_data_ff, cmd_reg_ff,
                                                         6'h00, cmd_rd_ff, 1'b0};
               ashc_pkg::AV_STATUS:   o_avs_readdata <= {16'h0000, rdata_ff, 6'h00, nack_ff, busy};
               ashc_pkg::AV_IRQ_STAT: o_avs_readdata <= {30'h0, irq_st_ff};
               ashc_pkg::AV_IRQ_MASK: o_avs_readdata <= {30'h0, irq_en_ff};
               default:               o_avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // command holds register pointer and data; a go while busy is dropped
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         cmd_reg_ff  <= 8'h00;
         cmd_data_ff <= 8'h00;
         cmd_rd_ff   <= 1'b0;
      end
      else if (go)
      begin
         cmd_rd_ff   <= i_avs_writedata[1];
         cmd_reg_ff  <= i_avs_writedata[15:8];
         cmd_data_ff <= i_avs_writedata[23:16];
      end
   end

   // sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         irq_st_ff <= 2'h0;
         irq_en_ff <= 2'h0;
      end
      else
      begin
         if (wr_now && i_avs_address == ashc_pkg::AV_IRQ_MASK)
            irq_en_ff <= i_avs_writedata[1:0];
         irq_st_ff <= (irq_st_ff & ~((wr_now && i_avs_address == ashc_pkg::AV_IRQ_STAT)
                                     ? i_avs_writedata[1:0] : 2'h0))
                      | {~p2_ff[0], done_ff};
      end
   end
   assign o_irq = |(irq_st_ff & irq_en_ff);

   // ==========================================================
   // bit engine: four quarter steps per scl period
   logic [15:0] qcnt_ff;
   logic        tick;
   logic [1:0]  q_ff;
   logic [3:0]  bit_ff;
   logic [2:0]  bi_ff;
   logic [7:0]  rx_ff;
   logic        scl_oe_n_ff;
   logic        sda_oe_n_ff;
   logic [7:0]  tx_byte;
   assign tick           = qcnt_ff == 16'(QTR - 1);
   assign bus.h_scl_o    = 1'b0;
   assign bus.h_sda_o    = 1'b0;
   assign bus.h_scl_oe_n = scl_oe_n_ff;
   assign bus.h_sda_oe_n = sda_oe_n_ff;

   // byte order: addr+w, pointer, data | repeated start, addr+r, read byte
   function automatic logic [7:0] byte_for(input logic [2:0] idx);
      case (idx)
         3'h0:    byte_for = {ashc_pkg::SLAVE_ADDR, 1'b0};
         3'h1:    byte_for = cmd_reg_ff;
         3'h2:    byte_for = cmd_data_ff;
         3'h3:    byte_for = {ashc_pkg::SLAVE_ADDR, 1'b1};
         default: byte_for = 8'hff;
      endcase
   endfunction
   assign tx_byte = byte_for(bi_ff);

   always_ff @(posedge i_clk)
   begin
      if (i_srst || st_ff == M_IDLE || tick)
         qcnt_ff <= 16'h0;
      else
         qcnt_ff <= qcnt_ff + 16'h1;
   end

   always_ff @(posedge i_clk)
   begin
      done_ff <= 1'b0;
      if (i_srst)
      begin
         st_ff       <= M_IDLE;
         q_ff        <= 2'h0;
         bit_ff      <= 4'h0;
         bi_ff       <= 3'h0;
         rx_ff       <= 8'h00;
         rdata_ff    <= 8'h00;
         nack_ff     <= 1'b0;
         scl_oe_n_ff <= 1'b1;
         sda_oe_n_ff <= 1'b1;
      end
      else if (st_ff == M_IDLE)
      begin
         q_ff <= 2'h0;
         if (go)
         begin
            st_ff   <= M_START;
            bi_ff   <= 3'h0;
            nack_ff <= 1'b0;
         end
      end
      else if (tick)
      begin
         q_ff <= q_ff + 2'h1;
         case (st_ff)
            M_START:
               case (q_ff)
                  2'h0:    sda_oe_n_ff <= 1'b1;
                  2'h1:    scl_oe_n_ff <= 1'b1;
                  2'h2:    sda_oe_n_ff <= 1'b0;
                  default:
                  begin
                     scl_oe_n_ff <= 1'b0;
                     bit_ff      <= 4'h0;
                     st_ff       <= M_BIT;
                  end
               endcase
            M_BIT:
               case (q_ff)
                  2'h0:    sda_oe_n_ff <= (bit_ff == 4'h8) | (bi_ff == 3'h4)
                                          | tx_byte[3'(7 - bit_ff)];
                  2'h1:    scl_oe_n_ff <= 1'b1;
                  2'h2:
                     if (bit_ff != 4'h8)
                        rx_ff <= {rx_ff[6:0], p2_ff[1]};
                     else if (p2_ff[1] && bi_ff != 3'h4)
                        nack_ff <= 1'b1;
                  default:
                  begin
                     scl_oe_n_ff <= 1'b0;
                     bit_ff      <= bit_ff + 4'h1;
                     if (bit_ff == 4'h8)
                     begin
                        bit_ff <= 4'h0;
                        if (nack_ff || (!cmd_rd_ff && bi_ff == 3'h2))
                           st_ff <= M_STOP;
                        else if (bi_ff == 3'h4)
                        begin
                           rdata_ff <= rx_ff;
                           st_ff    <= M_STOP;
                        end
                        else if (cmd_rd_ff && bi_ff == 3'h1)
                        begin
                           bi_ff <= 3'h3;
                           st_ff <= M_START;
                        end
                        else
                           bi_ff <= bi_ff + 3'h1;
                     end
                  end
               endcase
            M_STOP:
               case (q_ff)
                  2'h0:    sda_oe_n_ff <= 1'b0;
                  2'h1:    scl_oe_n_ff <= 1'b1;
                  2'h2:    sda_oe_n_ff <= 1'b1;
                  default:
                  begin
                     st_ff   <= M_IDLE;
                     done_ff <= 1'b1;
                  end
               endcase
            default:
               st_ff <= M_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verif/ashc_monitor.sv ====
// concurrent checks on the i2c wires and the interrupt line
`timescale 1ns/1ps
`default_nettype none
module ashc_monitor
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // link wires
   input wire logic h_scl_oe_n,
   input wire logic h_sda_oe_n,
   input wire logic d_sda_oe_n,
   input wire logic attach_interrupt_n,
   input wire logic scl,
   input wire logic sda
);
   // ====
   // one domain, so clock and reset are given once
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   rst_idle_a: assert property ($past(i_srst) |-> d_sda_oe_n && attach_interrupt_n
      && h_scl_oe_n && h_sda_oe_n) else $error("link not idle after reset");
   irq_masked_a: assert property ($fell(i_srst) |-> attach_interrupt_n[*8])
      else $error("interrupt low while masked");
   dev_drive_a: assert property ($fell(d_sda_oe_n) |-> !scl)
      else $error("device drove sda while scl high");
   dev_release_a: assert property ($rose(d_sda_oe_n) |-> !scl)
      else $error("device released sda while scl high");
   sda_bound_a: assert property ($fell(d_sda_oe_n) |-> ##[1:200] $rose(d_sda_oe_n))
      else $error("device held sda too long");
   // qtr of 4 gives two quarters of 4 clocks per scl level
   scl_high_a: assert property ($rose(scl) |-> scl[*7])
      else $error("scl high phase too short");
   scl_low_a: assert property ($fell(scl) |-> (!scl)[*7])
      else $error("scl low phase too short");
   frame_host_a: assert property (scl && $past(scl) && $changed(sda)
      |-> $changed(h_sda_oe_n)) else $error("start or stop not made by master");
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench: avalon orders turn into i2c transfers to the device
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        bat = 1'b0, io = 1'b1, vbus = 1'b0;
   logic [4:0]  id = ashc_pkg::ID_OPEN;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0, wr = 1'b0;
   logic [31:0] wd = 32'h0, rdata, s;
   logic        wait_r, irq, p_h, p_h1, boot, mode;
   int          errors = 0, n_tests = 0;
   ashc_if bus ();
   // ====
   // short quarters keep each transfer near 600 clocks
   ashc_host #(.QTR(4)) ashc_host_i (.i_clk, .i_srst, .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_r), .o_irq(irq), .bus);
   ashc_device ashc_device_i (.i_clk, .i_srst, .i_bat_valid(bat), .i_host_io_supply(io),
      .i_usb_bus_voltage_in(vbus), .i_connector_id_sense(id), .o_path_host(p_h),
      .o_path_host1(p_h1), .o_factory_boot(boot), .o_factory_mode(mode), .bus);
   ashc_monitor ashc_monitor_i (.i_clk, .i_srst, .h_scl_oe_n(bus.h_scl_oe_n),
      .h_sda_oe_n(bus.h_sda_oe_n), .d_sda_oe_n(bus.d_sda_oe_n),
      .attach_interrupt_n(bus.attach_interrupt_n), .scl(bus.scl), .sda(bus.sda));
   always #10 i_clk = ~i_clk;
   // ====
   task automatic summarize();
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one avalon cycle; held until waitrequest is seen low, result left in s
   task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge i_clk);
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      do @(posedge i_clk); while (wait_r !== 1'b0);
      s = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // one i2c transfer, polled until the controller is idle again
   task automatic xfer(input logic r, input logic [7:0] p, input logic [7:0] d);
      av(ashc_pkg::AV_CMD, 1'b1, {8'h0, d, p, 6'h0, r, 1'b1});
      do av(ashc_pkg::AV_STATUS, 1'b0, 32'h0); while (s[0] !== 1'b0);
   endtask
   task automatic xr(input logic [7:0] p, input logic [7:0] e);
      xfer(1'b1, p, 8'h0);
      chk({23'h0, s[15:8], s[1]}, {23'h0, e, 1'b0});
   endtask
   task automatic xw(input logic [7:0] p, input logic [7:0] d);
      xfer(1'b0, p, d);
      chk({31'h0, s[1]}, 32'h0);
   endtask
   // ====
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_srst <= 1'b0;
      bat <= 1'b1;
      repeat (10) @(posedge i_clk);
      chk({27'h0, p_h, p_h1, boot, mode, irq}, 32'h0);
      xr(ashc_pkg::REG_CONTROL, ashc_pkg::CONTROL_RST);
      xw(ashc_pkg::REG_CONTROL, 8'h04);
      id <= ashc_pkg::ID_USB_ON;
      av(ashc_pkg::AV_IRQ_MASK, 1'b1, 32'h2);
      xr(ashc_pkg::REG_ADC, {3'h0, ashc_pkg::ID_USB_ON});
      chk({27'h0, p_h, p_h1, boot, mode, irq}, 32'h17);
      xr(ashc_pkg::REG_INT, 8'h03);
      xr(ashc_pkg::REG_INT, 8'h00);
      av(ashc_pkg::AV_IRQ_STAT, 1'b1, 32'h3);
      av(ashc_pkg::AV_IRQ_STAT, 1'b0, 32'h0);
      chk({29'h0, s[1:0], irq}, 32'h0);
      id <= ashc_pkg::ID_UART_ON;
      xr(ashc_pkg::REG_ADC, {3'h0, ashc_pkg::ID_UART_ON});
      chk({28'h0, p_h, p_h1, boot, mode}, 32'h7);
      xw(ashc_pkg::REG_CONTROL, 8'h00);
      xw(ashc_pkg::REG_MANUAL, 8'h01);
      chk({30'h0, p_h, p_h1}, 32'h2);
      xw(ashc_pkg::REG_MANUAL, 8'h03);
      chk({30'h0, p_h, p_h1}, 32'h2);
      id <= ashc_pkg::ID_OPEN;
      xw(ashc_pkg::REG_SW_RESET, 8'h01);
      xr(ashc_pkg::REG_CONTROL, ashc_pkg::CONTROL_RST);
      chk({28'h0, p_h, p_h1, boot, mode}, 32'h0);
      id <= ashc_pkg::ID_UART_OFF;
      xr(ashc_pkg::REG_ADC, {3'h0, ashc_pkg::ID_UART_OFF});
      chk({28'h0, p_h, p_h1, boot, mode}, 32'h5);
      id <= ashc_pkg::ID_USB_OFF;
      xr(ashc_pkg::REG_ADC, {3'h0, ashc_pkg::ID_USB_OFF});
      chk({28'h0, p_h, p_h1, boot, mode}, 32'h9);
      id <= ashc_pkg::ID_OPEN;
      vbus <= 1'b1;
      xr(ashc_pkg::REG_DEV_TYPE, 8'h01);
      chk({30'h0, p_h, bus.attach_interrupt_n}, 32'h3);
      io <= 1'b0;
      xfer(1'b1, ashc_pkg::REG_CONTROL, 8'h0);
      chk({31'h0, s[1]}, 32'h1);
      summarize();
   end
   // watchdog: about four times the expected run
   initial
   begin
      repeat (30000) @(posedge i_clk);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
